// ### tlni_consts.svh
// Constants of the two-level nested interrupt unit.
`ifndef TLNI_CONSTS_SVH
`define TLNI_CONSTS_SVH
`define TLNI_NUM_SRC      15
`define TLNI_IDX_EXT0     0
`define TLNI_IDX_TWOWIRE  1
`define TLNI_IDX_ADC      2
`define TLNI_IDX_TIMER0   3
`define TLNI_IDX_CAP0     4
`define TLNI_IDX_CMP0     5
`define TLNI_IDX_EXT1     6
`define TLNI_IDX_CAP1     7
`define TLNI_IDX_CMP1     8
`define TLNI_IDX_TIMER1   9
`define TLNI_IDX_CAP2     10
`define TLNI_IDX_CMP2     11
`define TLNI_IDX_UART     12
`define TLNI_IDX_CAP3     13
`define TLNI_IDX_T2OVF    14
`define TLNI_EN_A_EXT0    0
`define TLNI_EN_A_TIMER0  1
`define TLNI_EN_A_EXT1    2
`define TLNI_EN_A_TIMER1  3
`define TLNI_EN_A_UART    4
`define TLNI_EN_A_TWOWIRE 5
`define TLNI_EN_A_ADC     6
`define TLNI_EN_A_GLOBAL  7
`define TLNI_EN_B_CAP0    0
`define TLNI_EN_B_CMP0    4
`define TLNI_EN_B_T2OVF   7
`define TLNI_REG_RESET    8'h00
`define TLNI_VEC_BASE     16'h0003
`define TLNI_VEC_STEP     16'h0008
`define TLNI_IDLE_WAKE    15'h124b
`endif

// ### tlni_core_model.sv
// Core timing and external level requester that face the interrupt unit.
`default_nettype none
module tlni_core_model (
   // Clock and reset.
   input  wire logic                    clock_in,
   input  wire logic                    sys_rst_in,
   // Bench controls and calls seen.
   input  wire logic                    run_in,
   input  wire logic                    level_req_in,
   input  wire logic                    pin_in,
   input  wire tlni_pkg::tlni_call_type call_in,
   // Core timing and shared pin.
   output logic                         sample_phase_out,
   output logic                         last_cycle_out,
   output logic                         instr_done_out,
   output logic                         ext_irq0_pin_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] phase_reg = 2'h0;
   logic       hold_reg = 1'b0;
   // A machine cycle lasts four clocks; everything changes on the falling edge.
   always @(negedge clock_in) begin
      phase_reg        <= sys_rst_in ? 2'h0 : phase_reg + 2'h1;
      sample_phase_out <= !sys_rst_in && phase_reg == 2'h2;
      instr_done_out   <= !sys_rst_in && run_in && phase_reg == 2'h3;
      last_cycle_out   <= !sys_rst_in && run_in;
      if (sys_rst_in || (call_in.call && call_in.source == 4'h0))
         hold_reg <= 1'b0;
      else if (level_req_in)
         hold_reg <= 1'b1;
   end
   // Open-drain requesters share the pin with a pull-up, so any of them pulls it low.
   assign ext_irq0_pin_out = pin_in & ~hold_reg;
endmodule
`default_nettype wire

// ### tlni_edge_detect.sv
// Pin synchroniser and edge detector for one external request input.
`default_nettype none
module tlni_edge_detect (
   // Clock and reset.
   input  wire logic clock_in,
   input  wire logic sys_rst_in,
   input  wire logic clk_en_in,
   // Pin and selection.
   input  wire logic pin_in,
   input  wire logic rise_en_in,
   input  wire logic fall_en_in,
   // Results.
   output logic      level_out,
   output logic      event_out
);
   logic sync1_reg, sync2_reg, last_reg;
   logic sync1_next, sync2_next, last_next;

   always_comb begin
      sync1_next = sync1_reg;
      sync2_next = sync2_reg;
      last_next  = last_reg;
      if (clk_en_in) begin
         sync1_next = pin_in;
         sync2_next = sync1_reg;
         last_next  = sync2_reg;
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         last_reg  <= 1'b1;
      end else begin
         sync1_reg <= sync1_next;
         sync2_reg <= sync2_next;
         last_reg  <= last_next;
      end
   end

   assign level_out = sync2_reg;
   assign event_out = clk_en_in & ((rise_en_in & sync2_reg & ~last_reg) |
                                   (fall_en_in & ~sync2_reg & last_reg));
endmodule
`default_nettype wire

// ### tlni_pkg.sv
// Types of the two-level nested interrupt unit.
`default_nettype none
package tlni_pkg;
   typedef struct packed {
      logic [7:0] enable_a;
      logic [7:0] enable_b;
      logic [7:0] priority_a;
      logic [7:0] priority_b;
   } tlni_cfg_type;
   typedef struct packed {
      logic       call;
      logic       high;
      logic [3:0] source;
      logic [15:0] vector;
   } tlni_call_type;
   typedef enum logic [1:0] {
      TLNI_CAP_OFF,
      TLNI_CAP_RISE,
      TLNI_CAP_FALL,
      TLNI_CAP_BOTH
   } tlni_edge_type;
endpackage
`default_nettype wire

// ### tlni_unit.sv
// Two-level nested interrupt unit with fifteen sources.
`include "tlni_consts.svh"
`default_nettype none
module tlni_unit (
   // Clock, reset and enable.
   input  wire logic                 clock_in,
   input  wire logic                 sys_rst_in,
   input  wire logic                 clk_en_in,
   // Core timing.
   input  wire logic                 sample_phase_in,
   input  wire logic                 last_cycle_in,
   input  wire logic                 return_from_interrupt_in,
   input  wire logic                 cfg_access_in,
   input  wire logic                 instr_done_in,
   input  wire logic                 idle_in,
   // Configuration.
   input  wire tlni_pkg::tlni_cfg_type cfg_in,
   input  wire logic                 ext0_edge_select_in,
   input  wire logic                 ext1_edge_select_in,
   input  wire logic [7:0]           capture_edge_sel_in,
   // Pins.
   input  wire logic                 ext_irq0_pin_in,
   input  wire logic                 ext_irq1_pin_in,
   input  wire logic [3:0]           capture_input_pin_in,
   // Peripheral set pulses.
   input  wire logic                 timer0_overflow_set_in,
   input  wire logic                 timer1_overflow_set_in,
   input  wire logic [7:0]           timer2_event_set_in,
   input  wire logic                 uart_rx_done_set_in,
   input  wire logic                 uart_tx_done_set_in,
   input  wire logic                 twowire_event_set_in,
   input  wire logic                 adc_done_set_in,
   input  wire logic                 seconds_tick_set_in,
   // Software flag writes.
   input  wire logic [17:0]          sw_set_in,
   input  wire logic [17:0]          sw_clr_in,
   // Results.
   output logic [17:0]               flags_out,
   output tlni_pkg::tlni_call_type   call_out,
   output logic [1:0]                active_level_out,
   output logic                      idle_wake_out
);
   // Flag layout: 0 ext0, 1 ext1, 2 timer0, 3 timer1, 4..11 timer2
   // (capture 0..3, compare 0..2, overflow), 12 rx, 13 tx, 14 two-wire,
   // 15 adc, 16 seconds, 17 unused.
   localparam int NF = 18;

   logic          ext0_lvl, ext1_lvl, ext0_evt, ext1_evt;
   logic [3:0]    cap_evt;
   logic [NF-1:0] flag_reg, flag_next;
   logic [14:0]   sample_reg, sample_next;
   logic [1:0]    active_reg, active_next;
   logic          hold_reg, hold_next;
   tlni_pkg::tlni_call_type call_reg, call_next;
   logic          wake_reg, wake_next;
   logic [14:0]   req, en_vec, pri_vec;
   logic [3:0]    win_idx;
   logic          win_high, win_any;

   tlni_edge_detect u_ext0 (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .clk_en_in  (clk_en_in),
      .pin_in     (ext_irq0_pin_in),
      .rise_en_in (1'b0),
      .fall_en_in (1'b1),
      .level_out  (ext0_lvl),
      .event_out  (ext0_evt)
   );
   tlni_edge_detect u_ext1 (
      .clock_in   (clock_in),
      .sys_rst_in (sys_rst_in),
      .clk_en_in  (clk_en_in),
      .pin_in     (ext_irq1_pin_in),
      .rise_en_in (1'b0),
      .fall_en_in (1'b1),
      .level_out  (ext1_lvl),
      .event_out  (ext1_evt)
   );
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_cap
         tlni_edge_detect u_cap (
            .clock_in   (clock_in),
            .sys_rst_in (sys_rst_in),
            .clk_en_in  (clk_en_in),
            .pin_in     (capture_input_pin_in[g]),
            .rise_en_in (capture_edge_sel_in[2*g]),
            .fall_en_in (capture_edge_sel_in[2*g+1]),
            .level_out  (),
            .event_out  (cap_evt[g])
         );
      end
   endgenerate

   // Maps a polled source index onto its vector address.
   function automatic logic [15:0] vec_of(input logic [3:0] idx);
      vec_of = `TLNI_VEC_BASE + ({12'h000, idx} * `TLNI_VEC_STEP);
   endfunction

   // Source requests in polling order.
   always_comb begin
      req = '0;
      req[`TLNI_IDX_EXT0]    = flag_reg[0];
      req[`TLNI_IDX_TWOWIRE] = flag_reg[14];
      req[`TLNI_IDX_ADC]     = flag_reg[15];
      req[`TLNI_IDX_TIMER0]  = flag_reg[2];
      req[`TLNI_IDX_CAP0]    = flag_reg[4];
      req[`TLNI_IDX_CMP0]    = flag_reg[8];
      req[`TLNI_IDX_EXT1]    = flag_reg[1] | flag_reg[16];
      req[`TLNI_IDX_CAP1]    = flag_reg[5];
      req[`TLNI_IDX_CMP1]    = flag_reg[9];
      req[`TLNI_IDX_TIMER1]  = flag_reg[3];
      req[`TLNI_IDX_CAP2]    = flag_reg[6];
      req[`TLNI_IDX_CMP2]    = flag_reg[10];
      req[`TLNI_IDX_UART]    = flag_reg[12] | flag_reg[13];
      req[`TLNI_IDX_CAP3]    = flag_reg[7];
      req[`TLNI_IDX_T2OVF]   = flag_reg[11];
   end

   // Enable and priority bits in polling order.
   always_comb begin
      en_vec  = {cfg_in.enable_b[7], cfg_in.enable_b[3], cfg_in.enable_a[4],
                 cfg_in.enable_b[6], cfg_in.enable_b[2], cfg_in.enable_a[3],
                 cfg_in.enable_b[5], cfg_in.enable_b[1], cfg_in.enable_a[2],
                 cfg_in.enable_b[4], cfg_in.enable_b[0], cfg_in.enable_a[1],
                 cfg_in.enable_a[6], cfg_in.enable_a[5], cfg_in.enable_a[0]};
      pri_vec = {cfg_in.priority_b[7], cfg_in.priority_b[3], cfg_in.priority_a[4],
                 cfg_in.priority_b[6], cfg_in.priority_b[2], cfg_in.priority_a[3],
                 cfg_in.priority_b[5], cfg_in.priority_b[1], cfg_in.priority_a[2],
                 cfg_in.priority_b[4], cfg_in.priority_b[0], cfg_in.priority_a[1],
                 cfg_in.priority_a[6], cfg_in.priority_a[5], cfg_in.priority_a[0]};
      if (!cfg_in.enable_a[`TLNI_EN_A_GLOBAL]) begin
         en_vec = '0;
      end
   end

   // Winner: any high request beats low, lowest index first in a level.
   always_comb begin
      logic [14:0] hi_req;
      logic [14:0] lo_req;
      hi_req   = sample_reg & en_vec & pri_vec;
      lo_req   = sample_reg & en_vec & ~pri_vec;
      win_idx  = 4'h0;
      win_high = 1'b0;
      win_any  = 1'b0;
      for (int i = 14; i >= 0; i--) begin
         if (lo_req[i]) begin
            win_idx = 4'(i);
            win_any = 1'b1;
         end
      end
      for (int i = 14; i >= 0; i--) begin
         if (hi_req[i]) begin
            win_idx  = 4'(i);
            win_high = 1'b1;
            win_any  = 1'b1;
         end
      end
   end

   // Sample, block and call.
   always_comb begin
      logic blocked;
      blocked     = 1'b0;
      sample_next = sample_reg;
      active_next = active_reg;
      hold_next   = hold_reg;
      call_next   = call_reg;
      call_next.call = 1'b0;
      wake_next   = wake_reg;
      if (clk_en_in) begin
         if (sample_phase_in) begin
            sample_next = req;
         end
         if (return_from_interrupt_in | cfg_access_in) begin
            hold_next = 1'b1;
         end else if (instr_done_in) begin
            hold_next = 1'b0;
         end
         blocked = active_reg[1] | (active_reg[0] & ~win_high) |
                   ~last_cycle_in | hold_reg | return_from_interrupt_in |
                   cfg_access_in;
         if (return_from_interrupt_in) begin
            if (active_reg[1]) begin
               active_next[1] = 1'b0;
            end else begin
               active_next[0] = 1'b0;
            end
         end else if (win_any && !blocked) begin
            call_next.call   = 1'b1;
            call_next.high   = win_high;
            call_next.source = win_idx;
            call_next.vector = vec_of(win_idx);
            active_next[win_high] = 1'b1;
            sample_next = '0;
         end
         wake_next = idle_in & |(req & en_vec & 15'(`TLNI_IDLE_WAKE));
      end
   end

   // Flag set and clear; set wins over every clear.
   always_comb begin
      logic [NF-1:0] hw_set;
      logic [NF-1:0] hw_clr;
      hw_set = '0;
      hw_clr = '0;
      // Level mode follows the pin; edge mode latches the falling edge.
      hw_set[0]  = ext0_edge_select_in ? ext0_evt : ~ext0_lvl;
      hw_set[1]  = ext1_edge_select_in ? ext1_evt : ~ext1_lvl;
      hw_clr[0]  = ~ext0_edge_select_in & ext0_lvl;
      hw_clr[1]  = ~ext1_edge_select_in & ext1_lvl;
      hw_set[2]  = timer0_overflow_set_in;
      hw_set[3]  = timer1_overflow_set_in;
      hw_set[11:4] = timer2_event_set_in | {4'h0, cap_evt};
      hw_set[12] = uart_rx_done_set_in;
      hw_set[13] = uart_tx_done_set_in;
      hw_set[14] = twowire_event_set_in;
      hw_set[15] = adc_done_set_in;
      hw_set[16] = seconds_tick_set_in;
      if (call_next.call) begin
         case (call_next.source)
            4'(`TLNI_IDX_EXT0):   hw_clr[0] = hw_clr[0] | ext0_edge_select_in;
            4'(`TLNI_IDX_EXT1):   hw_clr[1] = hw_clr[1] | ext1_edge_select_in;
            4'(`TLNI_IDX_TIMER0): hw_clr[2] = 1'b1;
            4'(`TLNI_IDX_TIMER1): hw_clr[3] = 1'b1;
            default:              hw_clr = hw_clr;
         endcase
      end
      flag_next = flag_reg;
      if (clk_en_in) begin
         flag_next = (flag_reg & ~(hw_clr | sw_clr_in)) | hw_set |
                     (sw_set_in & ~18'h08000);
         flag_next[17] = 1'b0;
      end
   end

   always_ff @(posedge clock_in) begin
      if (sys_rst_in) begin
         flag_reg   <= '0;
         sample_reg <= '0;
         active_reg <= '0;
         hold_reg   <= 1'b0;
         call_reg   <= '0;
         wake_reg   <= 1'b0;
      end else begin
         flag_reg   <= flag_next;
         sample_reg <= sample_next;
         active_reg <= active_next;
         hold_reg   <= hold_next;
         call_reg   <= call_next;
         wake_reg   <= wake_next;
      end
   end

   assign flags_out        = flag_reg;
   assign call_out         = call_reg;
   assign active_level_out = active_reg;
   assign idle_wake_out    = wake_reg;

   a_high_no_preempt: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      active_reg[1] && !return_from_interrupt_in |=> !call_reg.call)
      else $error("call while high level active");
   a_low_block_low: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      call_reg.call
      |-> !$past(active_reg[1]) && (call_reg.high || !$past(active_reg[0])))
      else $error("call over an equal or higher active level");
   a_ret_holds_call: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      clk_en_in && return_from_interrupt_in |=> !call_reg.call)
      else $error("call right after return");
   a_mid_instr_block: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      clk_en_in && !last_cycle_in |=> !call_reg.call)
      else $error("call mid instruction");
   a_call_sets_level: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      call_reg.call |-> active_reg[call_reg.high])
      else $error("active marker missing");
   a_vector_match: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      call_reg.call |-> call_reg.vector == vec_of(call_reg.source))
      else $error("vector mismatch");
   a_timer_clear: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      call_reg.call && call_reg.source == 4'(`TLNI_IDX_TIMER0)
      && !$past(timer0_overflow_set_in) && !$past(sw_set_in[2]) |-> !flag_reg[2])
      else $error("timer0 flag not cleared");
   a_global_off: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      !cfg_in.enable_a[`TLNI_EN_A_GLOBAL] |=> !call_reg.call)
      else $error("call with global enable off");
   a_adc_no_swset: assert property (@(posedge clock_in) disable iff (sys_rst_in)
      clk_en_in && !flag_reg[15] && !adc_done_set_in |=> !flag_reg[15])
      else $error("adc flag set without hardware");
   c_high_call: cover property (@(posedge clock_in) call_reg.call && call_reg.high);
   c_nest: cover property (@(posedge clock_in) call_reg.call && active_reg == 2'b11);
   c_wake: cover property (@(posedge clock_in) wake_reg);
endmodule
`default_nettype wire

// ### two_level_nested_interrupt_unit_tb_top.sv
// Self-checking bench of the two-level nested interrupt unit.
`default_nettype none
module two_level_nested_interrupt_unit_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FBIT [14] = '{2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 12, 13, 14, 16};
   localparam int FSRC [14] = '{3, 9, 4, 7, 10, 13, 5, 8, 11, 14, 12, 12, 1, 6};
   localparam int WBIT [8]  = '{2, 3, 12, 13, 14, 16, 4, 11};
   logic                    clock_in = 1'b0;
   logic                    sys_rst_in = 1'b1;
   logic                    clk_en_in = 1'b1;
   logic                    return_from_interrupt_in = 1'b0;
   logic                    cfg_access_in = 1'b0;
   logic                    idle_in = 1'b0;
   logic                    ext0_edge_select_in = 1'b0;
   logic                    ext1_edge_select_in = 1'b0;
   logic [7:0]              capture_edge_sel_in = 8'hf9;
   logic                    ext_irq1_pin_in = 1'b1;
   logic [3:0]              capture_input_pin_in = 4'hf;
   logic [17:0]             sw_set_in = 18'h0;
   logic [17:0]             sw_clr_in = 18'h0;
   logic [17:0]             hw_set = 18'h0;
   tlni_pkg::tlni_cfg_type  cfg_in = 32'hffff_0000;
   logic                    run = 1'b1;
   logic                    lvl_req = 1'b0;
   logic                    pin0 = 1'b1;
   logic                    done_seen = 1'b0;
   logic                    sample_phase_in;
   logic                    last_cycle_in;
   logic                    instr_done_in;
   logic                    ext_irq0_pin_in;
   logic [17:0]             flags_out;
   tlni_pkg::tlni_call_type call_out;
   tlni_pkg::tlni_call_type seen_call;
   logic [1:0]              active_level_out;
   logic                    idle_wake_out;
   int                      fail_count = 0;
   int                      total_checks = 0;
   int                      cycles = 0;
   tlni_core_model core (
      .clock_in, .sys_rst_in, .run_in(run), .level_req_in(lvl_req), .pin_in(pin0),
      .call_in(call_out), .sample_phase_out(sample_phase_in),
      .last_cycle_out(last_cycle_in), .instr_done_out(instr_done_in),
      .ext_irq0_pin_out(ext_irq0_pin_in)
   );
   tlni_unit dut (
      .clock_in, .sys_rst_in, .clk_en_in, .sample_phase_in, .last_cycle_in,
      .return_from_interrupt_in, .cfg_access_in, .instr_done_in, .idle_in, .cfg_in,
      .ext0_edge_select_in, .ext1_edge_select_in, .capture_edge_sel_in, .ext_irq0_pin_in,
      .ext_irq1_pin_in, .capture_input_pin_in, .timer0_overflow_set_in(hw_set[2]),
      .timer1_overflow_set_in(hw_set[3]), .timer2_event_set_in(hw_set[11:4]),
      .uart_rx_done_set_in(hw_set[12]), .uart_tx_done_set_in(hw_set[13]),
      .twowire_event_set_in(hw_set[14]), .adc_done_set_in(hw_set[15]),
      .seconds_tick_set_in(hw_set[16]), .sw_set_in, .sw_clr_in, .flags_out, .call_out,
      .active_level_out, .idle_wake_out
   );
   always #2.5 clock_in = ~clock_in;
   // The whole run needs about 1000 cycles; a hang is cut off at 20000, well beyond that.
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (instr_done_in === 1'b1)
         done_seen <= 1'b1;
      if (cycles == 20000) begin
         fail_count++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done(input string name);
      $display("test %s done, mismatches so far %0d", name, fail_count);
   endtask
   task automatic set_flags(input logic [17:0] m, input bit hw);
      if (hw)
         hw_set = m;
      else
         sw_set_in = m;
      @(negedge clock_in);
      hw_set = 18'h0;
      sw_set_in = 18'h0;
   endtask
   task automatic clr_flags(input logic [17:0] m);
      sw_clr_in = m;
      @(negedge clock_in);
      sw_clr_in = 18'h0;
   endtask
   task automatic return_from_interrupt();
      return_from_interrupt_in = 1'b1;
      @(negedge clock_in);
      return_from_interrupt_in = 1'b0;
      @(negedge clock_in);
   endtask
   // Watches every cycle for the one-cycle call pulse and returns on a falling edge.
   task automatic wait_call(input int lim, output logic got);
      got = 1'b0;
      for (int i = 0; i < lim && !got; i++) begin
         @(posedge clock_in);
         #1;
         if (call_out.call === 1'b1) begin
            got = 1'b1;
            seen_call = call_out;
         end
      end
      @(negedge clock_in);
   endtask
   task automatic expect_call(input logic [3:0] src, input logic hi);
      logic got;
      wait_call(40, got);
      check(got, 1'b1);
      check(seen_call.source, src);
      check(seen_call.high, hi);
      check(seen_call.vector, 16'h0003 + 16'h0008 * src);
   endtask
   task automatic expect_none();
      logic got;
      wait_call(30, got);
      check(got, 1'b0);
   endtask
   initial begin
      repeat (20) @(negedge clock_in);
      sys_rst_in = 1'b0;
      @(negedge clock_in);
      check(flags_out, 18'h0);
      check(active_level_out, 2'h0);
      test_done("reset");
      for (int p = 0; p < 2; p++) begin
         for (int i = 0; i < 14; i++) begin
            set_flags(18'h1 << FBIT[i], p == 0);
            expect_call(FSRC[i][3:0], 1'b0);
            check(active_level_out, 2'h1);
            check(flags_out[FBIT[i]], FBIT[i] > 3);
            clr_flags(18'h1 << FBIT[i]);
            return_from_interrupt();
         end
      end
      check(active_level_out, 2'h0);
      test_done("sources");
      set_flags(18'h08000, 1'b0);
      expect_none();
      check(flags_out[15], 1'b0);
      set_flags(18'h08000, 1'b1);
      expect_call(4'h2, 1'b0);
      check(flags_out[15], 1'b1);
      clr_flags(18'h08000);
      return_from_interrupt();
      check(flags_out[15], 1'b0);
      test_done("adc");
      set_flags(18'h04008, 1'b0);
      expect_call(4'h1, 1'b0);
      clr_flags(18'h04000);
      return_from_interrupt();
      expect_call(4'h9, 1'b0);
      return_from_interrupt();
      cfg_in.priority_a = 8'h08;
      set_flags(18'h04008, 1'b0);
      expect_call(4'h9, 1'b1);
      check(active_level_out, 2'h2);
      expect_none();
      set_flags(18'h00008, 1'b0);
      expect_none();
      clr_flags(18'h00008);
      return_from_interrupt();
      expect_call(4'h1, 1'b0);
      set_flags(18'h00008, 1'b0);
      expect_call(4'h9, 1'b1);
      check(active_level_out, 2'h3);
      return_from_interrupt();
      check(active_level_out, 2'h1);
      clr_flags(18'h04000);
      return_from_interrupt();
      check(active_level_out, 2'h0);
      cfg_in.priority_a = 8'h00;
      test_done("priority");
      cfg_in.enable_a = 8'h7f;
      set_flags(18'h4, 1'b0);
      expect_none();
      cfg_in.enable_a = 8'hfd;
      expect_none();
      cfg_in.enable_a = 8'hff;
      expect_call(4'h3, 1'b0);
      return_from_interrupt();
      run = 1'b0;
      set_flags(18'h4, 1'b0);
      expect_none();
      clr_flags(18'h4);
      repeat (8) @(negedge clock_in);
      run = 1'b1;
      expect_none();
      run = 1'b0;
      set_flags(18'h4, 1'b0);
      cfg_access_in = 1'b1;
      @(negedge clock_in);
      cfg_access_in = 1'b0;
      done_seen = 1'b0;
      repeat (8) @(negedge clock_in);
      run = 1'b1;
      expect_call(4'h3, 1'b0);
      check(done_seen, 1'b1);
      return_from_interrupt();
      test_done("blocking");
      ext0_edge_select_in = 1'b1;
      pin0 = 1'b0;
      expect_call(4'h0, 1'b0);
      check(flags_out[0], 1'b0);
      return_from_interrupt();
      expect_none();
      pin0 = 1'b1;
      repeat (4) @(negedge clock_in);
      ext0_edge_select_in = 1'b0;
      repeat (4) @(negedge clock_in);
      lvl_req = 1'b1;
      repeat (2) @(negedge clock_in);
      lvl_req = 1'b0;
      expect_call(4'h0, 1'b0);
      check(flags_out[0], 1'b1);
      repeat (6) @(negedge clock_in);
      check(flags_out[0], 1'b0);
      return_from_interrupt();
      expect_none();
      ext1_edge_select_in = 1'b1;
      ext_irq1_pin_in = 1'b0;
      expect_call(4'h6, 1'b0);
      check(flags_out[1], 1'b0);
      ext_irq1_pin_in = 1'b1;
      return_from_interrupt();
      test_done("external pins");
      cfg_in.enable_b = 8'h00;
      for (int n = 0; n < 4; n++) begin
         for (int e = 0; e < 2; e++) begin
            capture_input_pin_in[n] = (e == 1);
            repeat (6) @(negedge clock_in);
            check(flags_out[4 + n], capture_edge_sel_in[2 * n + 1 - e]);
            clr_flags(18'h10 << n);
         end
      end
      cfg_in.enable_b = 8'hff;
      test_done("capture pins");
      run = 1'b0;
      idle_in = 1'b1;
      for (int i = 0; i < 8; i++) begin
         set_flags(18'h1 << WBIT[i], 1'b0);
         repeat (4) @(negedge clock_in);
         check(idle_wake_out, i < 6);
         clr_flags(18'h1 << WBIT[i]);
         repeat (4) @(negedge clock_in);
      end
      idle_in = 1'b0;
      run = 1'b1;
      test_done("idle wake");
      end_sim();
   end
endmodule
`default_nettype wire
